/* pkg/sap_pkg.sv */
// Shared constants and helpers for the stereo serial audio port
package sap_pkg;
  localparam int WORD_W = 16;
  localparam int CIC_W  = 21;
  localparam int CIC_SH = 3;
  localparam int CAL_SH = 4;
  localparam logic [1:0] FMT_RJ  = 2'h0;
  localparam logic [1:0] FMT_I2S = 2'h1;
  localparam logic [1:0] FMT_LJ  = 2'h2;
  localparam logic [1:0] FMT_WC  = 2'h3;
  localparam logic [3:0] HALF_256 = 4'h2;
  localparam logic [3:0] HALF_384 = 4'h3;
  localparam logic [2:0] MOD_256  = 3'h3;
  localparam logic [2:0] MOD_384  = 3'h5;
  localparam logic [5:0] DEC_LAST = 6'h3F;
  localparam logic [3:0] CAL_LAST = 4'hF;
  localparam logic [5:0] BI_LAST  = 6'h3F;
  localparam logic [4:0] POS_LJ   = 5'h00;
  localparam logic [4:0] POS_I2S  = 5'h01;
  localparam logic [4:0] POS_RJ   = 5'h10;
  localparam logic [4:0] WBITS    = 5'h0F;
  localparam logic signed [CIC_W-1:0] CIC_P1 = 21'sh000001;
  localparam logic signed [CIC_W-1:0] CIC_M1 = 21'sh1FFFFF;
  localparam logic signed [CIC_W-1:0] SAT_HI = 21'sh007FFF;
  localparam logic signed [CIC_W-1:0] SAT_LO = 21'sh1F8000;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_DATA = 8'h08;
  localparam int C_EN   = 0;
  localparam int C_DEVM = 1;
  localparam int C_PACK = 2;
  localparam int C_R384 = 3;
  localparam int C_FMT  = 4;
  localparam int C_CAL  = 6;
  localparam int C_WPOS = 8;
  localparam logic [31:0] CTRL_RST  = 32'h00000000;
  localparam logic [31:0] CTRL_MASK = 32'h00001F7F;
  localparam int S_AVAIL = 0;
  localparam int S_OVR   = 1;

  function automatic logic [3:0] half_per(input logic r3, input logic pk);
    logic [3:0] h;
    h = r3 ? HALF_384 : HALF_256;
    return pk ? {h[2:0], 1'b0} : h;
  endfunction

  function automatic logic side(input logic [5:0] bi, input logic pk);
    return pk ? bi[4] : bi[5];
  endfunction

  function automatic logic [4:0] pos(input logic [5:0] bi, input logic pk);
    return pk ? {1'b0, bi[3:0]} : bi[4:0];
  endfunction

  function automatic logic [4:0] start(input logic [1:0] fm, input logic pk);
    logic [4:0] s;
    s = POS_LJ;
    if (fm == FMT_I2S) begin
      s = POS_I2S;
    end
    if (fm == FMT_RJ && !pk) begin
      s = POS_RJ;
    end
    return s;
  endfunction

  function automatic logic [WORD_W-1:0] sat_word(
    input logic signed [CIC_W-1:0] v);
    logic signed [CIC_W-1:0] s;
    s = v >>> CIC_SH;
    if (s > SAT_HI) begin
      s = SAT_HI;
    end
    if (s < SAT_LO) begin
      s = SAT_LO;
    end
    return s[WORD_W-1:0];
  endfunction
endpackage

/* pkg/sap_link_if.sv */
// Serial link and strap pins between converter and receiver
`timescale 1ns/100ps
interface sap_link_if;
  logic       bclk_d;
  logic       bclk_d_oe;
  logic       bclk_h;
  logic       bclk_h_oe;
  logic       lrck_d;
  logic       lrck_d_oe;
  logic       lrck_h;
  logic       lrck_h_oe;
  logic       bclk;
  logic       lrck;
  logic       sdata;
  logic       wclk;
  logic       dev_master;
  logic       pack_en;
  logic       r384;
  logic       cal_req;
  logic [1:0] fmt;
  assign bclk = bclk_d_oe ? bclk_d : (bclk_h_oe ? bclk_h : 1'b1);
  assign lrck = lrck_d_oe ? lrck_d : (lrck_h_oe ? lrck_h : 1'b1);
  modport dev (output bclk_d, bclk_d_oe, lrck_d, lrck_d_oe, sdata,
               input bclk, lrck, wclk, dev_master, pack_en, r384,
               cal_req, fmt);
  modport host (output bclk_h, bclk_h_oe, lrck_h, lrck_h_oe, wclk,
                dev_master, pack_en, r384, cal_req, fmt,
                input bclk, lrck, sdata);
endinterface

/* rtl/sap_dev.sv */
// Converter end: decimators, sample FIFO and serial transmitter
`timescale 1ns/100ps
module sap_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_reg;
  logic [AW:0]  wp_next;
  logic [AW:0]  rp_reg;
  logic [AW:0]  rp_next;
  logic         push;
  logic         pop;

  always_comb begin
    in_ready  = (wp_reg - rp_reg) != (AW+1)'(D);
    out_valid = wp_reg != rp_reg;
    push      = in_valid & in_ready;
    pop       = out_valid & out_ready;
    wp_next   = wp_reg + (AW+1)'(push);
    rp_next   = rp_reg + (AW+1)'(pop);
    out_data  = mem[rp_reg[AW-1:0]];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
    end
  end

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wp_reg[AW-1:0]] <= in_data;
    end
  end
endmodule

module sap_dev #(
  parameter int MCLK_DIV = 4,
  parameter int FIFO_D   = 8
) (
  input  wire logic pclk,
  input  wire logic presetn,
  sap_link_if.dev   lnk,
  input  wire logic mod_l,
  input  wire logic mod_r,
  output logic      mod_tick,
  output logic      cal_busy
);
  typedef enum logic [1:0] {CAL_RUN = 2'b01, CAL_ACC = 2'b10} sap_cal_e;
  localparam int MW  = $clog2(MCLK_DIV) + 1;
  localparam int CW  = sap_pkg::CIC_W;
  localparam int CAW = CW + sap_pkg::CAL_SH;

  logic [MW-1:0] mc_reg;
  logic [MW-1:0] mc_next;
  logic [2:0]    oc_reg;
  logic [2:0]    oc_next;
  logic [2:0]    olast;
  logic [5:0]    dc_reg;
  logic [5:0]    dc_next;
  logic          mtick;
  logic          dtick;
  sap_cal_e      cs_reg;
  sap_cal_e      cs_next;
  logic [3:0]    cc_reg;
  logic [3:0]    cc_next;
  logic          cq_reg;
  logic          cal_go;
  logic          cal_end;
  logic [1:0]    mbit;
  logic [15:0]   wd [2];
  logic          pv_reg;
  logic          pv_next;
  logic          f_rdy;
  logic          f_val;
  logic          f_pop;
  logic [31:0]   f_dat;

  always_comb begin
    mtick    = mc_reg == MW'(MCLK_DIV - 1);
    mc_next  = mtick ? '0 : mc_reg + 1'b1;
    olast    = lnk.r384 ? sap_pkg::MOD_384 : sap_pkg::MOD_256;
    mod_tick = mtick & (oc_reg == olast);
    oc_next  = oc_reg;
    if (mtick) begin
      oc_next = (oc_reg == olast) ? '0 : oc_reg + 1'b1;
    end
    dtick   = mod_tick & (dc_reg == sap_pkg::DEC_LAST);
    dc_next = mod_tick ? dc_reg + 1'b1 : dc_reg;
  end

  always_comb begin
    cal_go   = lnk.cal_req & ~cq_reg;
    cal_end  = (cs_reg == CAL_ACC) & dtick & (cc_reg == sap_pkg::CAL_LAST);
    cal_busy = cs_reg == CAL_ACC;
    cs_next  = cs_reg;
    unique case (cs_reg)
      CAL_RUN: begin
        if (cal_go) begin
          cs_next = CAL_ACC;
        end
      end
      CAL_ACC: begin
        if (cal_end && !cal_go) begin
          cs_next = CAL_RUN;
        end
      end
    endcase
    cc_next = (cal_go || !cal_busy) ? '0 : cc_reg + 4'(dtick);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_reg <= '0;
      oc_reg <= '0;
      dc_reg <= '0;
      cs_reg <= CAL_ACC;
      cc_reg <= '0;
      cq_reg <= 1'b0;
      pv_reg <= 1'b0;
    end else begin
      mc_reg <= mc_next;
      oc_reg <= oc_next;
      dc_reg <= dc_next;
      cs_reg <= cs_next;
      cc_reg <= cc_next;
      cq_reg <= lnk.cal_req;
      pv_reg <= pv_next;
    end
  end

  assign mbit = {mod_r, mod_l};
  for (genvar g = 0; g < 2; g++) begin : g_ch
    logic signed [CW-1:0]  ig_reg [3];
    logic signed [CW-1:0]  ig_next [3];
    logic signed [CW-1:0]  dl_reg [3];
    logic signed [CW-1:0]  dl_next [3];
    logic signed [CW-1:0]  cb [4];
    logic signed [CAW-1:0] ac_reg;
    logic signed [CAW-1:0] ac_next;
    logic signed [CAW-1:0] ac_sum;
    logic signed [CW-1:0]  of_reg;
    logic signed [CW-1:0]  of_next;
    logic [15:0]           wd_reg;
    logic [15:0]           wd_next;
    always_comb begin
      ig_next = ig_reg;
      dl_next = dl_reg;
      cb[0]   = ig_reg[2];
      for (int k = 0; k < 3; k++) begin
        cb[k+1] = cb[k] - dl_reg[k];
      end
      if (mod_tick) begin
        ig_next[0] = ig_reg[0] + (mbit[g] ? sap_pkg::CIC_P1 : sap_pkg::CIC_M1);
        ig_next[1] = ig_reg[1] + ig_reg[0];
        ig_next[2] = ig_reg[2] + ig_reg[1];
      end
      wd_next = wd_reg;
      if (dtick) begin
        for (int k = 0; k < 3; k++) begin
          dl_next[k] = cb[k];
        end
        wd_next = sap_pkg::sat_word(cb[3] - of_reg);
      end
      ac_sum  = ac_reg + CAW'(cb[3]);
      ac_next = ac_reg;
      of_next = of_reg;
      if (cal_go) begin
        ac_next = '0;
      end else if (cal_busy && dtick) begin
        ac_next = ac_sum;
      end
      if (cal_end) begin
        of_next = CW'(ac_sum >>> sap_pkg::CAL_SH);
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ig_reg <= '{default: '0};
        dl_reg <= '{default: '0};
        ac_reg <= '0;
        of_reg <= '0;
        wd_reg <= '0;
      end else begin
        ig_reg <= ig_next;
        dl_reg <= dl_next;
        ac_reg <= ac_next;
        of_reg <= of_next;
        wd_reg <= wd_next;
      end
    end
    assign wd[g] = wd_reg;
  end

  // Pair waits here while the FIFO is full; a newer pair replaces it
  assign pv_next = dtick | (pv_reg & ~f_rdy);

  sap_fifo #(
    .W (32),
    .D (FIFO_D)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_data   ({wd[0], wd[1]}),
    .in_valid  (pv_reg),
    .in_ready  (f_rdy),
    .out_data  (f_dat),
    .out_valid (f_val),
    .out_ready (f_pop)
  );

  logic [3:0]  hc_reg;
  logic [3:0]  hc_next;
  logic [3:0]  half;
  logic        bk_reg;
  logic        bk_next;
  logic        lr_reg;
  logic        lr_next;
  logic        bq_reg;
  logic        lq_reg;
  logic        lq_next;
  logic        wq_reg;
  logic        wq_next;
  logic [5:0]  bi_reg;
  logic [5:0]  bi_next;
  logic [5:0]  inc;
  logic        mfall;
  logic        mrise;
  logic        tx;
  logic        rx;
  logic        ld;
  logic        sd_reg;
  logic        sd_next;
  logic [14:0] sh_reg;
  logic [14:0] sh_next;
  logic [4:0]  rm_reg;
  logic [4:0]  rm_next;
  logic [31:0] fw_reg;
  logic [31:0] cur;
  logic [15:0] word;

  always_comb begin
    half    = sap_pkg::half_per(lnk.r384, lnk.pack_en);
    hc_next = hc_reg;
    bk_next = bk_reg;
    mfall   = 1'b0;
    mrise   = 1'b0;
    if (mtick && lnk.dev_master) begin
      if (hc_reg == half - 4'h1) begin
        hc_next = '0;
        bk_next = ~bk_reg;
        mfall   = bk_reg;
        mrise   = ~bk_reg;
      end else begin
        hc_next = hc_reg + 4'h1;
      end
    end
    tx      = lnk.dev_master ? mfall : (bq_reg & ~lnk.bclk);
    rx      = lnk.dev_master ? mrise : (~bq_reg & lnk.bclk);
    inc     = bi_reg + 6'h01;
    inc[5]  = inc[5] & ~lnk.pack_en;
    bi_next = bi_reg;
    lq_next = lq_reg;
    lr_next = lr_reg;
    if (tx) begin
      bi_next = (!lnk.dev_master && lq_reg && !lnk.lrck) ? '0 : inc;
      lq_next = lnk.lrck;
      lr_next = sap_pkg::side(bi_next, lnk.pack_en);
    end
    wq_next = rx ? lnk.wclk : wq_reg;
    f_pop   = tx & (bi_next == '0);
    cur     = (f_pop && f_val) ? f_dat : fw_reg;
    word    = sap_pkg::side(bi_next, lnk.pack_en) ? cur[15:0] : cur[31:16];
    if (lnk.fmt == sap_pkg::FMT_WC) begin
      ld = wq_reg;
    end else begin
      ld = sap_pkg::pos(bi_next, lnk.pack_en)
           == sap_pkg::start(lnk.fmt, lnk.pack_en);
    end
    sd_next = sd_reg;
    sh_next = sh_reg;
    rm_next = rm_reg;
    if (tx) begin
      if (ld) begin
        sd_next = word[15];
        sh_next = word[14:0];
        rm_next = sap_pkg::WBITS;
      end else if (rm_reg != '0) begin
        sd_next = sh_reg[14];
        sh_next = {sh_reg[13:0], 1'b0};
        rm_next = rm_reg - 5'h01;
      end else begin
        sd_next = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hc_reg <= '0;
      bk_reg <= 1'b1;
      lr_reg <= 1'b1;
      bq_reg <= 1'b1;
      lq_reg <= 1'b1;
      wq_reg <= 1'b0;
      bi_reg <= sap_pkg::BI_LAST;
      sd_reg <= 1'b0;
      sh_reg <= '0;
      rm_reg <= '0;
      fw_reg <= '0;
    end else begin
      hc_reg <= hc_next;
      bk_reg <= bk_next;
      lr_reg <= lr_next;
      bq_reg <= lnk.bclk;
      lq_reg <= lq_next;
      wq_reg <= wq_next;
      bi_reg <= bi_next;
      sd_reg <= sd_next;
      sh_reg <= sh_next;
      rm_reg <= rm_next;
      fw_reg <= cur;
    end
  end

  assign lnk.bclk_d    = bk_reg;
  assign lnk.bclk_d_oe = lnk.dev_master;
  assign lnk.lrck_d    = lr_reg;
  assign lnk.lrck_d_oe = lnk.dev_master;
  assign lnk.sdata     = sd_reg;
endmodule

/* rtl/sap_host.sv */
// Receiver end: APB registers, strap drive and serial receiver
`timescale 1ns/100ps
module sap_host #(
  parameter int AW       = 8,
  parameter int MCLK_DIV = 4
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [AW-1:0] paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  sap_link_if.host           lnk
);
  localparam int MW = $clog2(MCLK_DIV) + 1;
  logic [31:0]   ct_reg;
  logic [31:0]   ct_next;
  logic [31:0]   dr_reg;
  logic [31:0]   dr_next;
  logic [15:0]   hl_reg;
  logic [15:0]   hl_next;
  logic          av_reg;
  logic          av_next;
  logic          ov_reg;
  logic          ov_next;
  logic          hit_c;
  logic          hit_s;
  logic          hit_d;
  logic          wr;
  logic          rd_d;
  logic          en;
  logic          hm;
  logic          pk;
  logic [1:0]    fm;
  logic [4:0]    wp;
  logic [MW-1:0] mc_reg;
  logic [MW-1:0] mc_next;
  logic [3:0]    hc_reg;
  logic [3:0]    hc_next;
  logic [3:0]    half;
  logic          bk_reg;
  logic          bk_next;
  logic          lr_reg;
  logic          lr_next;
  logic          bq_reg;
  logic          lq_reg;
  logic          lq_next;
  logic          wc_reg;
  logic          wc_next;
  logic [5:0]    bi_reg;
  logic [5:0]    bi_next;
  logic [5:0]    inc;
  logic          tx;
  logic          rx;
  logic          mfall;
  logic          mrise;
  logic          st;
  logic          done;
  logic          pair;
  logic [14:0]   sr_reg;
  logic [14:0]   sr_next;
  logic [4:0]    rc_reg;
  logic [4:0]    rc_next;
  logic          ws_reg;
  logic          ws_next;
  logic [15:0]   word;

  always_comb begin
    en      = ct_reg[sap_pkg::C_EN];
    hm      = ~ct_reg[sap_pkg::C_DEVM];
    pk      = ct_reg[sap_pkg::C_PACK];
    fm      = ct_reg[sap_pkg::C_FMT +: 2];
    wp      = ct_reg[sap_pkg::C_WPOS +: 5];
    hit_c   = paddr == AW'(sap_pkg::A_CTRL);
    hit_s   = paddr == AW'(sap_pkg::A_STAT);
    hit_d   = paddr == AW'(sap_pkg::A_DATA);
    pready  = 1'b1;
    pslverr = psel & penable & ~(hit_c | hit_s | hit_d);
    wr      = psel & penable & pwrite;
    rd_d    = psel & penable & ~pwrite & hit_d;
    prdata  = '0;
    if (hit_c) begin
      prdata = ct_reg;
    end else if (hit_s) begin
      prdata[sap_pkg::S_AVAIL] = av_reg;
      prdata[sap_pkg::S_OVR]   = ov_reg;
    end else if (hit_d) begin
      prdata = dr_reg;
    end
    ct_next = (wr && hit_c) ? (pwdata & sap_pkg::CTRL_MASK) : ct_reg;
  end

  always_comb begin
    mc_next = (mc_reg == MW'(MCLK_DIV - 1)) ? '0 : mc_reg + 1'b1;
    half    = sap_pkg::half_per(ct_reg[sap_pkg::C_R384], pk);
    hc_next = hc_reg;
    bk_next = bk_reg;
    mfall   = 1'b0;
    mrise   = 1'b0;
    if (hm && en && mc_reg == MW'(MCLK_DIV - 1)) begin
      if (hc_reg == half - 4'h1) begin
        hc_next = '0;
        bk_next = ~bk_reg;
        mfall   = bk_reg;
        mrise   = ~bk_reg;
      end else begin
        hc_next = hc_reg + 4'h1;
      end
    end
    tx      = hm ? mfall : (bq_reg & ~lnk.bclk);
    rx      = (hm ? mrise : (~bq_reg & lnk.bclk)) & en;
    inc     = bi_reg + 6'h01;
    inc[5]  = inc[5] & ~pk;
    bi_next = bi_reg;
    lq_next = lq_reg;
    lr_next = lr_reg;
    wc_next = wc_reg;
    if (tx) begin
      bi_next = (!hm && lq_reg && !lnk.lrck) ? '0 : inc;
      lq_next = lnk.lrck;
      lr_next = sap_pkg::side(bi_next, pk);
      wc_next = (fm == sap_pkg::FMT_WC)
                && (sap_pkg::pos(bi_next, pk) == wp - 5'h01);
    end
    if (fm == sap_pkg::FMT_WC) begin
      st = sap_pkg::pos(bi_reg, pk) == wp;
    end else begin
      st = sap_pkg::pos(bi_reg, pk) == sap_pkg::start(fm, pk);
    end
    sr_next = sr_reg;
    rc_next = rc_reg;
    ws_next = ws_reg;
    if (rx && st) begin
      sr_next = {14'h0000, lnk.sdata};
      rc_next = sap_pkg::WBITS;
      ws_next = sap_pkg::side(bi_reg, pk);
    end else if (rx && rc_reg != '0) begin
      sr_next = {sr_reg[13:0], lnk.sdata};
      rc_next = rc_reg - 5'h01;
    end
    done    = rx & ~st & (rc_reg == 5'h01);
    word    = {sr_reg, lnk.sdata};
    hl_next = (done && !ws_reg) ? word : hl_reg;
    pair    = done & ws_reg;
    dr_next = pair ? {hl_reg, word} : dr_reg;
    av_next = pair | (av_reg & ~rd_d);
    ov_next = (pair & av_reg & ~rd_d)
              | (ov_reg & ~(wr & hit_s & pwdata[sap_pkg::S_OVR]));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ct_reg <= sap_pkg::CTRL_RST;
      dr_reg <= '0;
      hl_reg <= '0;
      av_reg <= 1'b0;
      ov_reg <= 1'b0;
      mc_reg <= '0;
      hc_reg <= '0;
      bk_reg <= 1'b1;
      lr_reg <= 1'b1;
      bq_reg <= 1'b1;
      lq_reg <= 1'b1;
      wc_reg <= 1'b0;
      bi_reg <= sap_pkg::BI_LAST;
      sr_reg <= '0;
      rc_reg <= '0;
      ws_reg <= 1'b0;
    end else begin
      ct_reg <= ct_next;
      dr_reg <= dr_next;
      hl_reg <= hl_next;
      av_reg <= av_next;
      ov_reg <= ov_next;
      mc_reg <= mc_next;
      hc_reg <= hc_next;
      bk_reg <= bk_next;
      lr_reg <= lr_next;
      bq_reg <= lnk.bclk;
      lq_reg <= lq_next;
      wc_reg <= wc_next;
      bi_reg <= bi_next;
      sr_reg <= sr_next;
      rc_reg <= rc_next;
      ws_reg <= ws_next;
    end
  end

  assign lnk.bclk_h     = bk_reg;
  assign lnk.bclk_h_oe  = hm;
  assign lnk.lrck_h     = lr_reg;
  assign lnk.lrck_h_oe  = hm;
  assign lnk.wclk       = wc_reg;
  assign lnk.dev_master = ct_reg[sap_pkg::C_DEVM];
  assign lnk.pack_en    = pk;
  assign lnk.r384       = ct_reg[sap_pkg::C_R384];
  assign lnk.fmt        = fm;
  assign lnk.cal_req    = ct_reg[sap_pkg::C_CAL];
endmodule

/* testbench/sap_chk.sv */
// Link checks between converter and receiver ends
`timescale 1ns/100ps
module sap_chk #(
  parameter int MCLK_DIV = 4
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       bclk,
  input wire logic       lrck,
  input wire logic       sdata,
  input wire logic       wclk,
  input wire logic       dev_master,
  input wire logic       pack_en,
  input wire logic       r384,
  input wire logic [1:0] fmt,
  input wire logic       bclk_d_oe,
  input wire logic       lrck_d_oe,
  input wire logic       bclk_h_oe
);
  logic [5:0] bit_reg, bit_next, tim_reg, tim_next, st;
  logic [4:0] cfg_reg;
  logic [1:0] seen_reg, seen_next;
  logic       bq_reg, lq_reg, same, ok;
  int         hp;
  assign same = cfg_reg == {dev_master, pack_en, r384, fmt};
  assign ok = (seen_reg == 2'h2) && same;
  // Bit count in half, time since bclk edge
  always_comb begin
    bit_next = bit_reg;
    tim_next = tim_reg + 6'h01;
    seen_next = seen_reg;
    hp = pack_en ? (r384 ? 6 : 4) : (r384 ? 3 : 2);
    st = (fmt == sap_pkg::FMT_I2S) ? 6'h01 : 6'h00;
    if (fmt == sap_pkg::FMT_RJ && !pack_en) begin
      st = 6'h10;
    end
    if (bclk && !bq_reg) begin
      bit_next = bit_reg + 6'h01;
    end
    if (bclk != bq_reg) begin
      tim_next = 6'h00;
    end
    // Two lrck edges after a strap change before halves are trusted
    if (lrck != lq_reg) begin
      bit_next = 6'h00;
      seen_next = (seen_reg == 2'h2) ? 2'h2 : seen_reg + 2'h1;
    end
    if (tim_reg == 6'h3F || !same) begin
      seen_next = 2'h0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_reg <= 6'h00;
      tim_reg <= 6'h00;
      seen_reg <= 2'h0;
      bq_reg <= 1'b1;
      lq_reg <= 1'b1;
      cfg_reg <= 5'h00;
    end else begin
      bit_reg <= bit_next;
      tim_reg <= tim_next;
      seen_reg <= seen_next;
      bq_reg <= bclk;
      lq_reg <= lrck;
      cfg_reg <= {dev_master, pack_en, r384, fmt};
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_master_drives:
    assert property (dev_master && $past(dev_master, 4)
      |-> bclk_d_oe && lrck_d_oe && !bclk_h_oe) else $error("clock drive");
  a_slave_quiet:
    assert property (!dev_master [*5] |-> !bclk_d_oe && !lrck_d_oe)
      else $error("slave drives clocks");
  a_sdata_low:
    assert property ($changed(sdata) && ok |-> !bclk) else $error("sdata");
  a_half_bits:
    assert property ($changed(lrck) && ok
      |-> bit_reg == (pack_en ? 6'h10 : 6'h20)) else $error("half len");
  a_bit_time:
    assert property ($changed(bclk) && ok |-> tim_reg == hp * MCLK_DIV - 1)
      else $error("bit time");
  a_word_window:
    assert property ($rose(bclk) && ok && sdata && fmt != sap_pkg::FMT_WC
      |-> bit_reg >= st && bit_reg < st + 6'h10
      || fmt == sap_pkg::FMT_I2S && bit_reg == 6'h00) else $error("zero");
  a_wclk_wide:
    assert property (wclk && ok |-> fmt == sap_pkg::FMT_WC && !pack_en)
      else $error("wclk format");
  a_wclk_bit:
    assert property ($rose(wclk) && ok |-> wclk [*4] ##[1:20] !wclk)
      else $error("wclk length");
endmodule

/* testbench/tb_stereo_adc_serial_output_port.sv */
// Testbench joining converter and receiver over the link
`timescale 1ns/100ps
module tb_stereo_adc_serial_output_port;
  localparam int MD = 2;
  localparam int FS = 32768;
  logic        pclk, presetn, psel, penable, pwrite, mod_l, mod_r;
  logic        pready, pslverr, mod_tick, cal_busy, alt, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, cfg;
  int          num_errors, compares, seed;
  sap_link_if lnk ();
  sap_dev #(.MCLK_DIV(MD)) i_sap_dev (
    .pclk(pclk), .presetn(presetn), .lnk(lnk.dev), .mod_l(mod_l),
    .mod_r(mod_r), .mod_tick(mod_tick), .cal_busy(cal_busy));
  sap_host #(.MCLK_DIV(MD)) i_sap_host (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk.host));
  sap_chk #(.MCLK_DIV(MD)) i_sap_chk (
    .pclk(pclk), .presetn(presetn), .bclk(lnk.bclk), .lrck(lnk.lrck),
    .sdata(lnk.sdata), .wclk(lnk.wclk), .dev_master(lnk.dev_master),
    .pack_en(lnk.pack_en), .r384(lnk.r384), .fmt(lnk.fmt),
    .bclk_d_oe(lnk.bclk_d_oe), .lrck_d_oe(lnk.lrck_d_oe),
    .bclk_h_oe(lnk.bclk_h_oe));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Modulator bits: zero mean or full scale
  always @(posedge pclk) begin
    if (!presetn) begin
      mod_l <= 1'b0;
      mod_r <= 1'b0;
    end else if (mod_tick === 1'b1) begin
      mod_l <= alt ? ~mod_l : 1'b1;
      mod_r <= alt ? ~mod_r : 1'b0;
    end
  end
  function automatic logic [15:0] expw(input int lvl, input int off);
    int v;
    v = lvl - off;
    if (v > FS - 1) begin
      v = FS - 1;
    end
    if (v < -FS) begin
      v = -FS;
    end
    return v[15:0];
  endfunction
  task automatic end_of_test();
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic near(input logic [15:0] g, input logic [15:0] e);
    int d;
    d = int'($signed(g)) - int'($signed(e));
    compares++;
    if ($isunknown(g) || d > 64 || d < -64) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic pair();
    int k;
    k = 0;
    rd = 32'h0;
    while (rd[0] !== 1'b1 && k < 1000) begin
      apb(1'b0, sap_pkg::A_STAT, 32'h0);
      k++;
    end
    chk({31'h0, rd[0]}, 32'h1);
    apb(1'b0, sap_pkg::A_DATA, 32'h0);
  endtask
  task automatic wait_busy(input logic v);
    int k;
    k = 0;
    while (cal_busy !== v && k < 40000) begin
      k++;
      @(posedge pclk);
    end
    chk({31'h0, cal_busy}, {31'h0, v});
  endtask
  initial begin
    seed = 32'h5E9A;
    num_errors = 0;
    compares = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    alt = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wait_busy(1'b1);
    apb(1'b0, sap_pkg::A_CTRL, 32'h0);
    chk(rd, sap_pkg::CTRL_RST);
    apb(1'b1, 8'h0C, 32'hFFFFFFFF);
    chk({31'h0, er}, 32'h1);
    wait_busy(1'b0);
    alt <= 1'b0;
    // Every format, random role and ratio, random packing except in word-clock format
    for (int i = 0; i < 8; i++) begin
      cfg = 32'h0;
      cfg[5:4] = i[1:0];
      cfg[3:1] = 3'($random(seed));
      cfg[12:8] = 5'h01 + 5'(4'($random(seed)));
      if (i[1:0] == sap_pkg::FMT_WC) begin
        cfg[2] = 1'b0;
      end
      apb(1'b1, sap_pkg::A_CTRL, cfg);
      apb(1'b1, sap_pkg::A_CTRL, cfg | 32'h1);
      apb(1'b0, sap_pkg::A_CTRL, 32'h0);
      chk(rd, cfg | 32'h1);
      // FIFO latency plus the frames cut by the strap change
      repeat (i == 0 ? 16 : 5) pair();
      near(rd[31:16], expw(FS, 0));
      near(rd[15:0], expw(-FS, 0));
    end
    // Two unread pairs set overrun; write one clears it
    pair();
    repeat (1700) @(posedge pclk);
    apb(1'b0, sap_pkg::A_STAT, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, sap_pkg::A_DATA, 32'h0);
    apb(1'b1, sap_pkg::A_STAT, 32'h2);
    apb(1'b0, sap_pkg::A_STAT, 32'h0);
    chk({31'h0, rd[1]}, 32'h0);
    apb(1'b1, sap_pkg::A_CTRL, cfg | 32'h41);
    wait_busy(1'b1);
    wait_busy(1'b0);
    repeat (16) pair();
    near(rd[31:16], expw(FS, FS));
    near(rd[15:0], expw(-FS, -FS));
    end_of_test();
  end
  initial begin
    #400000;
    chk(32'h0, 32'h1);
    end_of_test();
  end
endmodule
